// *** verilog/lud_pkg.sv ***
// constants for the lin/uart data buffer and control block
package lud_pkg;
  // register addresses (byte offsets on the plain register port)
  localparam logic [3:0] LUD_A_CTRL = 4'h0;
  localparam logic [3:0] LUD_A_STAT = 4'h1;
  localparam logic [3:0] LUD_A_IREN = 4'h2;
  localparam logic [3:0] LUD_A_ERR = 4'h3;
  localparam logic [3:0] LUD_A_BTR = 4'h4;
  localparam logic [3:0] LUD_A_BRL = 4'h5;
  localparam logic [3:0] LUD_A_BRH = 4'h6;
  localparam logic [3:0] LUD_A_DLR = 4'h7;
  localparam logic [3:0] LUD_A_IDR = 4'h8;
  localparam logic [3:0] LUD_A_SEL = 4'h9;
  localparam logic [3:0] LUD_A_DAT = 4'hA;
  // control register fields
  localparam int LUD_C_SWRES = 7;
  localparam int LUD_C_LEGACY = 6;
  localparam int LUD_C_CONF_LO = 4;
  localparam int LUD_C_ENA = 3;
  // status register fields
  localparam int LUD_S_BUSY = 4;
  localparam int LUD_S_ERR = 3;
  localparam int LUD_S_HDR = 2;
  localparam int LUD_S_TX = 1;
  localparam int LUD_S_RX = 0;
  // error register fields
  localparam int LUD_E_ABORT = 7;
  localparam int LUD_E_OVR = 5;
  // selection register fields
  localparam int LUD_SEL_AID = 3;
  // timing register fields
  localparam int LUD_B_DISR = 7;
  // reset values
  localparam logic [7:0] LUD_RST_ZERO = 8'h00;
  localparam logic [5:0] LUD_RST_BT = 6'h20;
  // special identifier range: upper four identifier bits all ones
  localparam logic [3:0] LUD_SPECIAL_HI = 4'hF;
  // length of the soft reset procedure
  localparam int LUD_SWRES_NS = 80;
  localparam int LUD_CLK_MHZ = 50;
  localparam int LUD_SWRES_CYC = (LUD_SWRES_NS * LUD_CLK_MHZ + 999) / 1000;
  // commands
  typedef enum logic [2:0] {
    LUD_CMD_RXHDR = 3'h0,
    LUD_CMD_TXHDR = 3'h1,
    LUD_CMD_RXRSP = 3'h2,
    LUD_CMD_TXRSP = 3'h3,
    LUD_CMD_UOFF = 3'h4
  } lud_cmd_t;
  // soft reset sequencer
  typedef enum logic {LUD_SR_IDLE, LUD_SR_RUN} lud_sr_t;
endpackage

// *** verilog/lud_ctrl.sv ***
// lin/uart data buffer, command, status and register control
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - identifier-in-checksum latched at response command
// - buffer reached only via index and data port
// - index advances after data access when enabled
// - index wraps from 7 to 0
// - disabled auto-increment keeps index; software writes it
// - frame byte n lives at slot n
// - uart mode: data port is single tx/rx byte
// - uart mode ignores selection register
// - debugger halt freezes engine and time-out
// - soft reset bit starts reset, self-clears
// - bit 6 selects legacy protocol and checksum
// - command field acts only with enable set
// - flags write-one clear; error clear wipes errors
// - uart data read/write clears rx/err/tx flags
// - config field selects checksum, time-out, listening
module lud_ctrl
  import lud_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic dbg_halt,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  // serial engine: command side
  output logic cmd_go,
  output logic [2:0] cmd_code,
  output logic uart_mode,
  output logic cks_with_id,
  output logic cks_enable,
  output logic timeout_enable,
  output logic listen_mode,
  output logic [1:0] config_sel,
  output logic engine_freeze,
  output logic engine_reset,
  output logic [11:0] baud_div,
  output logic [5:0] bit_samples,
  output logic resync_off,
  output logic [7:0] uart_tx_byte,
  // serial engine: events
  input wire logic eng_busy,
  input wire logic eng_hdr_done,
  input wire logic eng_tx_done,
  input wire logic eng_rx_done,
  input wire logic [7:0] eng_err,
  input wire logic [7:0] eng_uart_rx,
  // serial engine: frame buffer port
  input wire logic eng_buf_we,
  input wire logic [2:0] eng_buf_pos,
  input wire logic [7:0] eng_buf_wdata,
  output logic [7:0] eng_buf_rdata
);
  import lud_pkg::*;

  logic [7:0] ctrl_q;
  logic [3:0] stat_q;
  logic [3:0] iren_q;
  logic [7:0] err_q;
  logic disr_q;
  logic [5:0] bt_q;
  logic [11:0] div_q;
  logic [7:0] dlr_q;
  logic [5:0] id_q;
  logic [3:0] sel_q;
  logic [7:0] rxb_q;
  logic [7:0] buf_q [8];
  lud_sr_t sr_q;
  logic [7:0] sr_cnt_q;
  logic wr_ctrl, acc, do_rd, do_wr, ena, umode, clr, dat_rd, dat_wr, aid;
  logic [1:0] par;
  logic [7:0] rd_d;
  logic [7:0] err_set;

  assign ena = ctrl_q[LUD_C_ENA];
  assign umode = ena & ctrl_q[2];
  // internal registers except the frame buffer and the uart rx byte are held in reset while the procedure runs
  assign clr = (sr_q == LUD_SR_RUN);
  assign do_wr = reg_wr & ~clr;
  assign do_rd = reg_rd & ~clr;
  assign wr_ctrl = do_wr & (reg_addr == LUD_A_CTRL);
  // a command is taken only from a control write with enable set
  assign acc = wr_ctrl & reg_wdata[LUD_C_ENA];
  assign dat_rd = do_rd & (reg_addr == LUD_A_DAT);
  assign dat_wr = do_wr & (reg_addr == LUD_A_DAT);
  assign aid = sel_q[LUD_SEL_AID];
  // protected identifier parity bits
  assign par[0] = id_q[0] ^ id_q[1] ^ id_q[2] ^ id_q[4];
  assign par[1] = ~(id_q[1] ^ id_q[3] ^ id_q[4] ^ id_q[5]);

  // soft reset sequencer; a debugger halt stalls it like the engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sr_q <= LUD_SR_IDLE;
      sr_cnt_q <= 8'h00;
    end else if (clk_en && !dbg_halt) begin
      case (sr_q)
        LUD_SR_IDLE: begin
          if (wr_ctrl && reg_wdata[LUD_C_SWRES]) begin
            sr_q <= LUD_SR_RUN;
            sr_cnt_q <= 8'(LUD_SWRES_CYC - 1);
          end
        end
        LUD_SR_RUN: begin
          if (sr_cnt_q == 8'h00) begin
            sr_q <= LUD_SR_IDLE;
          end else begin
            sr_cnt_q <= sr_cnt_q - 8'h01;
          end
        end
        default: sr_q <= LUD_SR_IDLE;
      endcase
    end
  end

  // control register; the reset bit reads one until the procedure ends
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= LUD_RST_ZERO;
    end else if (clk_en) begin
      if (clr) begin
        ctrl_q <= {1'b1, 7'h00};
        if (!dbg_halt && sr_cnt_q == 8'h00) begin
          ctrl_q <= LUD_RST_ZERO;
        end
      end else if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  // command launch towards the serial engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_go <= 1'b0;
      cmd_code <= LUD_CMD_RXHDR;
      cks_with_id <= 1'b1;
    end else if (clk_en) begin
      cmd_go <= acc;
      if (acc) begin
        cmd_code <= reg_wdata[2:0];
      end
      // the choice holds for the whole response, later bit 6 changes do not reach it
      if (acc && (reg_wdata[2:0] == LUD_CMD_RXRSP || reg_wdata[2:0] == LUD_CMD_TXRSP)) begin
        cks_with_id <= ~reg_wdata[LUD_C_LEGACY];
      end
    end
  end

  // static configuration towards the engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uart_mode <= 1'b0;
      config_sel <= 2'b00;
      cks_enable <= 1'b1;
      timeout_enable <= 1'b1;
      listen_mode <= 1'b0;
      engine_freeze <= 1'b0;
      engine_reset <= 1'b0;
    end else if (clk_en) begin
      uart_mode <= umode;
      config_sel <= ctrl_q[LUD_C_CONF_LO +: 2];
      // in uart mode the field means parity; only listening is shared
      cks_enable <= ~umode & (ctrl_q[LUD_C_CONF_LO +: 2] != 2'b01);
      timeout_enable <= ~umode & ctrl_q[LUD_C_CONF_LO +: 2] != 2'b01
        & ctrl_q[LUD_C_CONF_LO +: 2] != 2'b10;
      listen_mode <= (ctrl_q[LUD_C_CONF_LO +: 2] == 2'b11);
      engine_freeze <= dbg_halt;
      engine_reset <= clr;
    end
  end

  // status flags: hardware set wins over a write-one clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_q <= 4'h0;
    end else if (clk_en) begin
      if (clr) begin
        stat_q <= 4'h0;
      end else begin
        if (do_wr && reg_addr == LUD_A_STAT && reg_wdata[LUD_S_HDR]) begin
          stat_q[LUD_S_HDR] <= 1'b0;
        end
        if ((do_wr && reg_addr == LUD_A_STAT && reg_wdata[LUD_S_TX]) || (umode && dat_wr)) begin
          stat_q[LUD_S_TX] <= 1'b0;
        end
        if ((do_wr && reg_addr == LUD_A_STAT && reg_wdata[LUD_S_RX]) || (umode && dat_rd)) begin
          stat_q[LUD_S_RX] <= 1'b0;
        end
        if (eng_hdr_done && !umode) begin
          stat_q[LUD_S_HDR] <= 1'b1;
        end
        if (eng_tx_done) begin
          stat_q[LUD_S_TX] <= 1'b1;
        end
        if (eng_rx_done) begin
          stat_q[LUD_S_RX] <= 1'b1;
        end
        stat_q[LUD_S_ERR] <= 1'b0;
      end
    end
  end

  // error register; the summary flag is the or of these bits
  always_comb begin
    err_set = eng_err;
    err_set[LUD_E_OVR] = eng_err[LUD_E_OVR]
      | (acc && eng_busy && !umode && reg_wdata[2:0] != LUD_CMD_RXHDR);
    err_set[LUD_E_ABORT] = eng_err[LUD_E_ABORT]
      | (acc && eng_busy && reg_wdata[2:0] == LUD_CMD_RXHDR);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      err_q <= LUD_RST_ZERO;
    end else if (clk_en) begin
      if (clr) begin
        err_q <= LUD_RST_ZERO;
      end else if ((do_wr && reg_addr == LUD_A_STAT && reg_wdata[LUD_S_ERR])
                   || (umode && dat_rd)) begin
        err_q <= err_set;
      end else begin
        err_q <= err_q | err_set;
      end
    end
  end

  // interrupt enable and single level interrupt output
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      iren_q <= 4'h0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (clr) begin
        iren_q <= 4'h0;
      end else if (do_wr && reg_addr == LUD_A_IREN) begin
        iren_q <= reg_wdata[3:0];
      end
      irq <= |({|err_q, stat_q[2:0]} & iren_q);
    end
  end

  // timing, baud, length and identifier registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      disr_q <= 1'b0;
      bt_q <= LUD_RST_BT;
      div_q <= 12'h000;
      dlr_q <= LUD_RST_ZERO;
      id_q <= 6'h00;
    end else if (clk_en) begin
      if (clr) begin
        disr_q <= 1'b0;
        bt_q <= LUD_RST_BT;
        div_q <= 12'h000;
        dlr_q <= LUD_RST_ZERO;
        id_q <= 6'h00;
      end else begin
        if (do_wr && reg_addr == LUD_A_BTR) begin
          disr_q <= reg_wdata[LUD_B_DISR];
          // sample count is writable only with resync disabled and the enable bit clear
          if (reg_wdata[LUD_B_DISR] && !ena) begin
            bt_q <= reg_wdata[5:0];
          end
        end
        if (do_wr && reg_addr == LUD_A_BRL) begin
          div_q[7:0] <= reg_wdata;
        end
        if (do_wr && reg_addr == LUD_A_BRH) begin
          div_q[11:8] <= reg_wdata[3:0];
        end
        if (umode) begin
          dlr_q <= LUD_RST_ZERO;
        end else if (do_wr && reg_addr == LUD_A_DLR) begin
          dlr_q <= reg_wdata;
        end
        if (do_wr && reg_addr == LUD_A_IDR) begin
          id_q <= reg_wdata[5:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      baud_div <= 12'h000;
      bit_samples <= LUD_RST_BT;
      resync_off <= 1'b0;
    end else if (clk_en) begin
      baud_div <= div_q;
      bit_samples <= bt_q;
      resync_off <= disr_q;
    end
  end

  // buffer index with wrap by 3-bit width
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_q <= 4'h0;
    end else if (clk_en) begin
      if (clr) begin
        sel_q <= 4'h0;
      end else if (do_wr && reg_addr == LUD_A_SEL) begin
        sel_q <= reg_wdata[3:0];
      end else if ((dat_rd || dat_wr) && !umode && !aid) begin
        sel_q[2:0] <= sel_q[2:0] + 3'h1;
      end
      // with auto-increment off the index simply stays put
    end
  end

  // frame buffer: engine writes slot of byte position, software via index
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_slot
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          buf_q[gi] <= LUD_RST_ZERO;
        end else if (clk_en) begin
          // engine wins a same-cycle clash so received bytes are never lost
          if (eng_buf_we && eng_buf_pos == 3'(gi)) begin
            buf_q[gi] <= eng_buf_wdata;
          end else if (dat_wr && !umode && sel_q[2:0] == 3'(gi)) begin
            buf_q[gi] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eng_buf_rdata <= LUD_RST_ZERO;
    end else if (clk_en) begin
      eng_buf_rdata <= buf_q[eng_buf_pos];
    end
  end

  // uart single byte path, no buffering
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uart_tx_byte <= LUD_RST_ZERO;
      rxb_q <= LUD_RST_ZERO;
    end else if (clk_en) begin
      if (dat_wr && umode) begin
        uart_tx_byte <= reg_wdata;
      end
      if (eng_rx_done && umode) begin
        rxb_q <= eng_uart_rx;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_d = LUD_RST_ZERO;
    case (reg_addr)
      LUD_A_CTRL: rd_d = ctrl_q;
      LUD_A_STAT: begin
        rd_d = {1'b0, 2'b00, eng_busy, |err_q, stat_q[2:0]};
        if (id_q[5:2] == LUD_SPECIAL_HI) begin
          rd_d[7:5] = {1'b1, id_q[1:0]};
        end
      end
      LUD_A_IREN: rd_d = {4'h0, iren_q};
      LUD_A_ERR: rd_d = err_q;
      LUD_A_BTR: rd_d = {disr_q, 1'b0, bt_q};
      LUD_A_BRL: rd_d = div_q[7:0];
      LUD_A_BRH: rd_d = {4'h0, div_q[11:8]};
      LUD_A_DLR: rd_d = dlr_q;
      LUD_A_IDR: rd_d = {par, id_q};
      LUD_A_SEL: rd_d = {4'h0, sel_q};
      LUD_A_DAT: rd_d = umode ? rxb_q : buf_q[sel_q[2:0]];
      default: rd_d = LUD_RST_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= LUD_RST_ZERO;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_d : LUD_RST_ZERO;
    end
  end
endmodule
`default_nettype wire

// *** verif/lud_ctrl_properties.sv ***
// port assertions for the lin/uart control block
`timescale 1ns/1ps
`default_nettype none
module lud_ctrl_properties
  import lud_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic dbg_halt,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // engine command side
  input wire logic cmd_go,
  input wire logic [2:0] cmd_code,
  input wire logic uart_mode,
  input wire logic cks_with_id,
  input wire logic cks_enable,
  input wire logic timeout_enable,
  input wire logic listen_mode,
  input wire logic [1:0] config_sel,
  input wire logic engine_freeze,
  input wire logic engine_reset
);
  import lud_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic ctrl_wr;
  // writes during a soft reset are dropped, so they are no cause
  assign ctrl_wr = reg_wr && clk_en && reg_addr == LUD_A_CTRL && !engine_reset;
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_unmapped; reg_rd && reg_addr > LUD_A_DAT |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cmd_ena; cmd_go |-> $past(ctrl_wr && reg_wdata[LUD_C_ENA]); endproperty
  a_cmd_ena: assert property (p_cmd_ena) else $error("command without enable");
  property p_cmd_code;
    ctrl_wr && reg_wdata[LUD_C_ENA] && !reg_wdata[LUD_C_SWRES] && !reg_wdata[2]
      |=> cmd_go && cmd_code == $past(reg_wdata[2:0]);
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("command not issued");
  property p_cks_hold;
    $changed(cks_with_id) |-> (cmd_go && cmd_code[2:1] == 2'b01) || engine_reset
      || $past(engine_reset);
  endproperty
  a_cks_hold: assert property (p_cks_hold) else $error("checksum choice moved");
  property p_cks_val;
    ctrl_wr && reg_wdata[LUD_C_ENA] && reg_wdata[2:1] == 2'b01 && !reg_wdata[LUD_C_SWRES]
      |=> cks_with_id == !$past(reg_wdata[LUD_C_LEGACY]);
  endproperty
  a_cks_val: assert property (p_cks_val) else $error("checksum choice wrong");
  property p_uart;
    // the mode output follows the stored control value one cycle later
    ctrl_wr && !reg_wdata[LUD_C_SWRES]
      |-> ##2 uart_mode == ($past(reg_wdata[3], 2) && $past(reg_wdata[2], 2));
  endproperty
  a_uart: assert property (p_uart) else $error("uart mode wrong");
  property p_cfg;
    !uart_mode |-> listen_mode == (config_sel == 2'b11) && cks_enable == (config_sel != 2'b01)
      && timeout_enable == (config_sel[1] == config_sel[0]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config decode wrong");
  property p_freeze; clk_en |=> engine_freeze == $past(dbg_halt); endproperty
  a_freeze: assert property (p_freeze) else $error("freeze not following halt");
  property p_sr_go; ctrl_wr && reg_wdata[LUD_C_SWRES] && !dbg_halt |-> ##2 engine_reset; endproperty
  a_sr_go: assert property (p_sr_go) else $error("soft reset not started");
  property p_sr_len; $rose(engine_reset) && !dbg_halt |-> engine_reset[*4] ##1 !engine_reset; endproperty
  a_sr_len: assert property (p_sr_len) else $error("soft reset length wrong");
  c_cmd: cover property (cmd_go);
  c_uart: cover property ($rose(uart_mode));
  c_sr: cover property ($rose(engine_reset));
endmodule
`default_nettype wire

// *** verif/lud_eng_model.sv ***
// behavioural serial engine beside the control block
`timescale 1ns/1ps
`default_nettype none
module lud_eng_model (
  // clock and command side
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_go,
  input wire logic [2:0] cmd_code,
  input wire logic [7:0] eng_buf_rdata,
  // events and buffer port
  output logic eng_busy,
  output logic eng_hdr_done,
  output logic eng_tx_done,
  output logic eng_rx_done,
  output logic [7:0] eng_err,
  output logic [7:0] eng_uart_rx,
  output logic eng_buf_we,
  output logic [2:0] eng_buf_pos,
  output logic [7:0] eng_buf_wdata
);
  initial begin
    {eng_hdr_done, eng_tx_done, eng_rx_done, eng_buf_we} = 4'h0;
    eng_err = 8'h00;
    eng_uart_rx = 8'hFF;
    eng_buf_pos = 3'h0;
    eng_buf_wdata = 8'hFF;
  end
  // a frame command keeps the engine busy until its response event
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      eng_busy <= 1'b0;
    else if (eng_rx_done || eng_tx_done)
      eng_busy <= 1'b0;
    else if (cmd_go && !cmd_code[2] && cmd_code != 3'h0)
      eng_busy <= 1'b1;
  end
  task automatic fire(input logic [2:0] ev, input logic [7:0] err, input logic [7:0] rx_byte);
    @(posedge ref_clk);
    {eng_hdr_done, eng_tx_done, eng_rx_done} <= ev;
    eng_err <= err;
    eng_uart_rx <= rx_byte;
    @(posedge ref_clk);
    {eng_hdr_done, eng_tx_done, eng_rx_done} <= 3'h0;
    eng_err <= 8'h00;
    // a stale byte must not look valid
    eng_uart_rx <= ~rx_byte;
  endtask
  // byte n of a frame goes to slot n
  task automatic put(input logic [2:0] pos, input logic [7:0] d);
    @(posedge ref_clk);
    eng_buf_we <= 1'b1;
    eng_buf_pos <= pos;
    eng_buf_wdata <= d;
    @(posedge ref_clk);
    eng_buf_we <= 1'b0;
    eng_buf_wdata <= ~d;
  endtask
  task automatic peek(input logic [2:0] pos, output logic [7:0] d);
    @(posedge ref_clk);
    eng_buf_pos <= pos;
    repeat (2) @(posedge ref_clk);
    #1 d = eng_buf_rdata;
  endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking testbench for the lin/uart control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lud_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic dbg_halt = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, uart_tx_byte, eng_err, eng_uart_rx, eng_buf_wdata, eng_buf_rdata, seen;
  logic irq, cmd_go, uart_mode, cks_with_id, cks_enable, timeout_enable, listen_mode;
  logic engine_freeze, engine_reset, resync_off, eng_busy, eng_hdr_done, eng_tx_done;
  logic eng_rx_done, eng_buf_we;
  logic [2:0] cmd_code, eng_buf_pos;
  logic [1:0] config_sel;
  logic [11:0] baud_div;
  logic [5:0] bit_samples;
  int n_errors = 0;
  int checks_done = 0;
  lud_ctrl dut (.*);
  lud_eng_model eng (.*);
  initial forever #10 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(what, 12'(exp), 12'(reg_rdata));
  endtask
  task automatic t_reset;
    rd(LUD_A_CTRL, 8'h00, "ctrl reset");
    rd(LUD_A_BTR, 8'h20, "bit timing reset");
    rd(LUD_A_IDR, 8'h80, "id reset");
    rd(4'hB, 8'h00, "unmapped read");
    chk("checksum with id", 12'h001, 12'(cks_with_id));
    wr(LUD_A_BRL, 8'h34);
    wr(LUD_A_BRH, 8'hFC);
    wr(LUD_A_BTR, 8'h8C);
    @(posedge ref_clk);
    #1 chk("baud divider", 12'hC34, baud_div);
    chk("bit samples", 12'h00C, 12'(bit_samples));
    chk("resync off", 12'h001, 12'(resync_off));
    $display("test reset done");
  endtask
  task automatic t_autoinc;
    wr(LUD_A_SEL, 8'h06);
    for (int i = 0; i < 3; i++) wr(LUD_A_DAT, 8'hA0 + 8'(i));
    rd(LUD_A_SEL, 8'h01, "index after wrap");
    eng.peek(3'h0, seen);
    chk("slot 0", 12'h0A2, 12'(seen));
    $display("test auto increment done");
  endtask
  task automatic t_noinc;
    wr(LUD_A_SEL, 8'h0A);
    wr(LUD_A_DAT, 8'h5A);
    wr(LUD_A_DAT, 8'h5B);
    rd(LUD_A_SEL, 8'h0A, "index held");
    rd(LUD_A_DAT, 8'h5B, "held slot");
    rd(LUD_A_DAT, 8'h5B, "held slot again");
    $display("test fixed index done");
  endtask
  task automatic t_engine;
    for (int i = 0; i < 8; i++) eng.put(3'(i), 8'h10 + 8'(i));
    wr(LUD_A_SEL, 8'h00);
    for (int i = 0; i < 8; i++) rd(LUD_A_DAT, 8'h10 + 8'(i), "frame byte");
    rd(LUD_A_SEL, 8'h00, "index after eight");
    $display("test engine buffer done");
  endtask
  task automatic t_cmd;
    wr(LUD_A_CTRL, 8'h02);
    #1 chk("disabled command", 12'h000, 12'(cmd_go));
    wr(LUD_A_IDR, 8'h3D);
    wr(LUD_A_CTRL, 8'h4A);
    #1 chk("rx response code", 12'h002, 12'(cmd_code));
    chk("classic checksum", 12'h000, 12'(cks_with_id));
    wr(LUD_A_CTRL, 8'h09);
    #1 chk("choice kept", 12'h000, 12'(cks_with_id));
    rd(LUD_A_ERR, 8'h20, "overrun");
    rd(LUD_A_STAT, 8'hB8, "busy and error");
    wr(LUD_A_IDR, 8'h00);
    wr(LUD_A_STAT, 8'h08);
    rd(LUD_A_ERR, 8'h00, "errors wiped");
    eng.fire(3'b001, 8'h00, 8'h00);
    rd(LUD_A_STAT, 8'h01, "rx done");
    wr(LUD_A_STAT, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(LUD_A_CTRL, 8'(c << LUD_C_CONF_LO));
      @(posedge ref_clk);
      #1 chk("listen", 12'(c == 3), 12'(listen_mode));
      chk("checksum on", 12'(c != 1), 12'(cks_enable));
      chk("time-out on", 12'(c == 0 || c == 3), 12'(timeout_enable));
    end
    $display("test commands done");
  endtask
  task automatic t_flags;
    wr(LUD_A_IREN, 8'h02);
    eng.fire(3'b111, 8'h00, 8'h00);
    rd(LUD_A_STAT, 8'h07, "flags set");
    chk("irq unmasked", 12'h001, 12'(irq));
    wr(LUD_A_STAT, 8'h02);
    rd(LUD_A_STAT, 8'h05, "tx flag cleared");
    chk("irq masked", 12'h000, 12'(irq));
    wr(LUD_A_STAT, 8'h05);
    rd(LUD_A_STAT, 8'h00, "all cleared");
    $display("test flags done");
  endtask
  task automatic t_uart;
    wr(LUD_A_SEL, 8'h03);
    wr(LUD_A_CTRL, 8'h0E);
    wr(LUD_A_DAT, 8'hC3);
    #1 chk("tx byte", 12'h0C3, 12'(uart_tx_byte));
    eng.fire(3'b011, 8'h10, 8'h5E);
    rd(LUD_A_STAT, 8'h0B, "uart flags");
    wr(LUD_A_DAT, 8'h77);
    rd(LUD_A_STAT, 8'h09, "tx cleared by write");
    rd(LUD_A_DAT, 8'h5E, "rx byte");
    rd(LUD_A_STAT, 8'h00, "rx and error cleared by read");
    rd(LUD_A_ERR, 8'h00, "framing wiped");
    rd(LUD_A_SEL, 8'h03, "select untouched");
    $display("test uart done");
  endtask
  task automatic t_swres(input logic halt);
    wr(LUD_A_IREN, 8'h0F);
    wr(LUD_A_CTRL, 8'h80);
    // a halted cpu writes nothing, so the halt comes after the start
    dbg_halt <= halt;
    rd(LUD_A_CTRL, 8'h80, "soft reset running");
    if (halt) begin
      repeat (8) @(posedge ref_clk);
      #1 chk("engine frozen", 12'h001, 12'(engine_freeze));
      rd(LUD_A_CTRL, 8'h80, "soft reset paused");
      @(posedge ref_clk);
      dbg_halt <= 1'b0;
    end
    // the procedure lasts four cycles, eight leaves margin
    repeat (8) @(posedge ref_clk);
    rd(LUD_A_CTRL, 8'h00, "soft reset bit cleared");
    rd(LUD_A_IREN, 8'h00, "enables cleared");
    $display("test soft reset done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_autoinc();
    t_noinc();
    t_engine();
    t_cmd();
    t_flags();
    t_uart();
    t_swres(1'b1);
    t_swres(1'b0);
    wrap_up();
  end
endmodule
bind lud_ctrl lud_ctrl_properties chk_i (.*);
`default_nettype wire
